// ### bench/pin_io_pulse_timer_bench.sv
// self-checking bench for the pin io pulse timer
`timescale 1ns/1ps
module pin_io_pulse_timer_bench;
  import pit_pkg::*;
  localparam int MS = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [15:0] pinIn;
  logic [15:0] pinOut;
  logic [15:0] pinOe_n;
  logic lowPower;
  logic [15:0] extLevel = 16'ha5c3;
  logic [31:0] d;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  // short millisecond keeps nap and pause runs brief
  pit_top #(.MS_CYC(MS)) pit_top_inst (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .lowPower(lowPower));
  pit_pin_model pit_pin_model_inst (.pinOut(pinOut), .pinOe_n(pinOe_n), .extLevel(extLevel),
    .pinIn(pinIn));

  // clock and a free cycle count for measuring spans
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chkr(input string nm, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // avalon write: hold until waitrequest low, then one idle edge so strobes never collide
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    address <= a;
    writedata <= v;
    write <= 1'b1;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    address <= a;
    read <= 1'b1;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    v = readdata;
    read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_reset();
    chk("pinOe_n", 32'h0000ffff, {16'h0, pinOe_n});
    rd(REG_DIR, d);
    chk("dir", 32'h0, d);
    rd(REG_IN, d);
    chk("input_level_bits", 32'h0000a5c3, d);
    rd(5'h1c, d);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
  endtask

  // latch write on an input stays hidden until the pin becomes an output
  task automatic t_latch_low();
    wr(REG_OUT, 32'h00008000);
    rd(REG_IN, d);
    chk("input_level_bits", 32'h0000a5c3, d);
    wr(REG_CMD, 32'h00000027);
    chk("pinOe_n", 32'h0000ff7f, {16'h0, pinOe_n});
    rd(REG_IN, d);
    chk("input_level_bits", 32'h0000a543, d);
    wr(REG_CMD, 32'h0000001f);
    rd(REG_DIR, d);
    chk("dir", 32'h00008080, d);
    rd(REG_OUT, d);
    chk("out", 32'h0, d);
    $display("test latch and low done");
  endtask

  task automatic t_pause(input int ms);
    int t0;
    int n;
    n = 0;
    wr(REG_ARG, ms);
    t0 = cyc;
    wr(REG_CMD, 32'h00000050);
    do begin
      rd(REG_STAT, d);
      n++;
    end while (d[STAT_BUSY_BIT] !== 1'b0 && n < 2000);
    if (ms > 0) chkr("pause cycles", ms * MS, (ms + 1) * MS + 20, cyc - t0);
    else chkr("pause zero", 0, 20, cyc - t0);
    $display("test pause done");
  endtask

  task automatic t_nap();
    int n;
    n = 0;
    wr(REG_ARG, 32'h1);
    wr(REG_CMD, 32'h00000060);
    while (lowPower !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (lowPower === 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chkr("nap cycles", 36 * MS - MS, 36 * MS + MS, n);
    n = 0;
    while (pinOe_n === 16'hffff && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chkr("wake cycles", 18 * MS - MS, 18 * MS + MS, n);
    chk("pinOe_n", 32'h00007f7f, {16'h0, pinOe_n});
    $display("test nap done");
  endtask

  // pin 3 is driven to the trigger level, then released onto that same level,
  // so only a fresh entry may start the count; falling run uses a byte result
  task automatic t_capture(input logic pol);
    int n;
    n = 0;
    wr(REG_CMD, pol ? 32'h00000043 : 32'h00000013);
    extLevel[3] <= pol;
    wr(REG_CMD, {22'h0, ~pol, pol, 8'h73});
    rd(REG_DIR, d);
    chk("dir", 32'h00008080, d);
    repeat (300) @(posedge clk);
    extLevel[3] <= ~pol;
    repeat (300) @(posedge clk);
    extLevel[3] <= pol;
    repeat (5 * TICK_CYC + 200) @(posedge clk);
    extLevel[3] <= ~pol;
    do begin
      rd(REG_STAT, d);
      n++;
    end while (d[STAT_DONE_BIT] !== 1'b1 && n < 1000);
    rd(REG_RES, d);
    chk("capture ticks", 32'h00000005, d);
    rd(REG_DIR, d);
    chk("dir", 32'h00008080, d);
    $display("test capture done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog sized well above the sum of all tests
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("BAD watchdog expected done seen hang");
    complete_run();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_latch_low();
    t_pause(3);
    t_pause(0);
    t_nap();
    t_capture(1'b1);
    t_capture(1'b0);
    complete_run();
  end
endmodule

// ### bench/pit_pin_model.sv
// external circuit on the sixteen pins: resistors set the level of undriven pins
`timescale 1ns/1ps
module pit_pin_model (
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOe_n,
  input wire logic [15:0] extLevel,
  output logic [15:0] pinIn
);
  // a driven pin shows its latch, an undriven one the resistor level, never a stale value
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pinIn[i] = pinOe_n[i] ? extLevel[i] : pinOut[i];
    end
  end
endmodule

// ### hw/pit_pkg.sv
// package: register map, command codes, timing constants for the pin io pulse timer
package pit_pkg;
  // register byte offsets on the avalon slave
  localparam logic [4:0] REG_DIR = 5'h00;
  localparam logic [4:0] REG_OUT = 5'h04;
  localparam logic [4:0] REG_IN = 5'h08;
  localparam logic [4:0] REG_CMD = 5'h0c;
  localparam logic [4:0] REG_ARG = 5'h10;
  localparam logic [4:0] REG_STAT = 5'h14;
  localparam logic [4:0] REG_RES = 5'h18;
  // command register fields
  localparam int CMD_PIN_LSB = 0;
  localparam int CMD_OP_LSB = 4;
  localparam int CMD_POL_BIT = 8;
  localparam int CMD_BYTE_BIT = 9;
  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_TMO_BIT = 2;
  localparam int STAT_OVF_BIT = 3;
  localparam int STAT_NAP_BIT = 4;
  localparam int STAT_WAKE_BIT = 5;
  // reset values
  localparam logic [15:0] DIR_RST = 16'h0000;
  localparam logic [15:0] OUT_RST = 16'h0000;
  localparam logic [15:0] ARG_RST = 16'h0000;
  // opcodes
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_LOW = 4'h1,
    OP_OUTPUT = 4'h2,
    OP_INPUT = 4'h3,
    OP_HIGH = 4'h4,
    OP_PAUSE = 4'h5,
    OP_NAP = 4'h6,
    OP_CAPTURE = 4'h7
  } pit_op_e;
  // timing
  localparam int CLK_NS = 5;
  localparam int TICK_NS = 2000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC_DFLT = MS_NS / CLK_NS;
  localparam int NAP_BASE_MS = 18;
  localparam int WAKE_MS = 18;
  localparam logic [15:0] CAP_MAX = 16'hffff;
endpackage

// ### hw/pit_tick_gen.sv
// timebase: 2 us and 1 ms tick strobes from the system clock
`timescale 1ns/1ps
module pit_tick_gen
  import pit_pkg::*;
#(
  parameter int MS_CYC = MS_CYC_DFLT
) (
  input wire logic clk,
  input wire logic rst,
  pit_tick_if.gen tk
);
  logic [8:0] usCnt_q;
  logic [31:0] msCnt_q;

  // 2 us divider, realigned on restart so the first tick is a full period away
  always_ff @(posedge clk) begin
    if (rst || tk.restart || usCnt_q == 9'(TICK_CYC - 1)) begin
      usCnt_q <= 9'h000;
    end else begin
      usCnt_q <= usCnt_q + 9'h001;
    end
  end

  // 1 ms divider from the same clock, so ms delays share its accuracy
  always_ff @(posedge clk) begin
    if (rst || tk.restart || msCnt_q == 32'(MS_CYC - 1)) begin
      msCnt_q <= 32'h0000_0000;
    end else begin
      msCnt_q <= msCnt_q + 32'h0000_0001;
    end
  end

  assign tk.tick2us = (usCnt_q == 9'(TICK_CYC - 1)) && !tk.restart;
  assign tk.tick1ms = (msCnt_q == 32'(MS_CYC - 1)) && !tk.restart;
endmodule

// ### hw/pit_tick_if.sv
// interface: tick strobes between the timebase and the command engine
`timescale 1ns/1ps
interface pit_tick_if;
  logic restart;
  logic tick2us;
  logic tick1ms;
  modport gen (input restart, output tick2us, output tick1ms);
  modport user (output restart, input tick2us, input tick1ms);
endinterface

// ### hw/pit_top.sv
// pin io pulse timer: sixteen pins, drive commands, pause, nap and pulse capture
`timescale 1ns/1ps
// Operation
// - drive-low sets direction one, latch zero
// - make-output sets only direction bit
// - reset makes all pins inputs
// - pin selector 0 to 15
// - nap lasts 18 ms times two^code
// - wake forces inputs 18 ms, then restores
// - pause stalls requested ms, up to 65535
// - ms timing from the one timebase
// - capture makes pin input, leaves it
// - polarity one rising, zero falling start
// - count 2 us ticks until next change
// - start only on a real transition
// - no trigger within 0.131 s returns zero
// - pulse over 0.131 s returns zero
// - 16-bit counter, byte keeps low eight
// - word result spans 0 to 65535
// - latch writes to inputs kept silently
// - input level shows pin or latch
module pit_top
  import pit_pkg::*;
#(
  parameter int MS_CYC = MS_CYC_DFLT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [15:0] pinIn,
  output logic [15:0] pinOut,
  output logic [15:0] pinOe_n,
  output logic lowPower
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PAUSE,
    ST_NAP,
    ST_WAKE,
    ST_CAP_WAIT,
    ST_CAP_RUN
  } pit_state_e;

  pit_tick_if tk ();

  pit_tick_gen #(.MS_CYC(MS_CYC)) uTick (
    .clk(clk),
    .rst(rst),
    .tk(tk)
  );

  // merge a write into a 16-bit register honoring the two low byte lanes
  function automatic logic [15:0] beMerge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    beMerge = old;
    if (be[0]) begin
      beMerge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      beMerge[15:8] = wd[15:8];
    end
  endfunction

  pit_state_e state_q;
  logic [15:0] dirQ_q;
  logic [15:0] outQ_q;
  logic [15:0] arg_q;
  logic [15:0] cnt_q;
  logic [15:0] result_q;
  logic [3:0] capPin_q;
  logic capPol_q;
  logic capByte_q;
  logic prevLvl_q;
  logic done_q;
  logic tmo_q;
  logic ovf_q;
  logic rdValid_q;
  logic [31:0] readdata_q;

  logic busy;
  logic cmdGo;
  pit_op_e cmdOp;
  logic [3:0] cmdPin;
  logic [15:0] dirEff;
  logic [15:0] inLevel;
  logic capLvl;
  logic [15:0] napMs;

  assign busy = (state_q != ST_IDLE);
  assign cmdOp = pit_op_e'(writedata[CMD_OP_LSB +: 4]);
  assign cmdPin = writedata[CMD_PIN_LSB +: 4];
  assign cmdGo = write && (address == REG_CMD) && !busy && byteenable[0];
  assign napMs = 16'(NAP_BASE_MS) << arg_q[2:0];
  assign capLvl = pinIn[capPin_q];

  // a command write while busy is held off, which is how pause stalls the caller
  assign waitrequest = (read && !rdValid_q) || (write && (address == REG_CMD) && busy);
  assign readdata = readdata_q;

  // wake-up forces every pin to input without touching the stored directions
  assign dirEff = (state_q == ST_WAKE) ? 16'h0000 : dirQ_q;
  assign pinOut = outQ_q;
  assign pinOe_n = ~dirEff;
  assign inLevel = (dirEff & outQ_q) | (~dirEff & pinIn);
  assign lowPower = (state_q == ST_NAP);

  // timebase realigns at each timed command and at the capture start edge; nap end needs
  // no realign since the ms divider wraps on that very tick, and a term built on the tick
  // would feed back into the tick itself
  assign tk.restart = (cmdGo && (cmdOp == OP_PAUSE || cmdOp == OP_NAP || cmdOp == OP_CAPTURE))
                      || (state_q == ST_CAP_WAIT && prevLvl_q != capPol_q
                          && capLvl == capPol_q);

  // direction bits: bus writes and pin commands, all inputs at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      dirQ_q <= DIR_RST;
    end else if (write && !waitrequest && address == REG_DIR) begin
      dirQ_q <= beMerge(dirQ_q, writedata, byteenable);
    end else if (cmdGo) begin
      case (cmdOp)
        OP_LOW: dirQ_q[cmdPin] <= 1'b1;
        OP_HIGH: dirQ_q[cmdPin] <= 1'b1;
        OP_OUTPUT: dirQ_q[cmdPin] <= 1'b1;
        OP_INPUT: dirQ_q[cmdPin] <= 1'b0;
        OP_CAPTURE: dirQ_q[cmdPin] <= 1'b0;
        default: dirQ_q <= dirQ_q;
      endcase
    end
  end

  // output latch: kept even for inputs, shows once the pin turns output
  always_ff @(posedge clk) begin
    if (rst) begin
      outQ_q <= OUT_RST;
    end else if (write && !waitrequest && address == REG_OUT) begin
      outQ_q <= beMerge(outQ_q, writedata, byteenable);
    end else if (cmdGo && cmdOp == OP_LOW) begin
      outQ_q[cmdPin] <= 1'b0;
    end else if (cmdGo && cmdOp == OP_HIGH) begin
      outQ_q[cmdPin] <= 1'b1;
    end
  end

  // argument: ms count for pause, period code for nap
  always_ff @(posedge clk) begin
    if (rst) begin
      arg_q <= ARG_RST;
    end else if (write && !waitrequest && address == REG_ARG) begin
      arg_q <= beMerge(arg_q, writedata, byteenable);
    end
  end

  // command engine: pause, nap with wake glitch, pulse capture
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      capPin_q <= 4'h0;
      capPol_q <= 1'b0;
      capByte_q <= 1'b0;
      prevLvl_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= 16'h0000;
          if (cmdGo) begin
            capPin_q <= cmdPin;
            capPol_q <= writedata[CMD_POL_BIT];
            capByte_q <= writedata[CMD_BYTE_BIT];
            prevLvl_q <= pinIn[cmdPin];
            case (cmdOp)
              OP_PAUSE: state_q <= (arg_q == 16'h0000) ? ST_IDLE : ST_PAUSE;
              OP_NAP: state_q <= ST_NAP;
              OP_CAPTURE: state_q <= ST_CAP_WAIT;
              default: state_q <= ST_IDLE;
            endcase
          end
        end
        ST_PAUSE: begin
          // ms ticks come from the system clock divider, no separate oscillator
          if (tk.tick1ms) begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == arg_q - 16'h0001) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_NAP: begin
          if (tk.tick1ms) begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == napMs - 16'h0001) begin
              cnt_q <= 16'h0000;
              state_q <= ST_WAKE;
            end
          end
        end
        ST_WAKE: begin
          if (tk.tick1ms) begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == 16'(WAKE_MS - 1)) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_CAP_WAIT: begin
          prevLvl_q <= capLvl;
          // level already at the polarity on entry does not count as a start
          if (prevLvl_q != capPol_q && capLvl == capPol_q) begin
            cnt_q <= 16'h0000;
            state_q <= ST_CAP_RUN;
          end else if (tk.tick2us) begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == CAP_MAX - 16'h0001) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_CAP_RUN: begin
          if (capLvl != capPol_q) begin
            state_q <= ST_IDLE;
          end else if (tk.tick2us) begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == CAP_MAX) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // capture result and completion flags; a new capture command clears the flags
  always_ff @(posedge clk) begin
    if (rst) begin
      result_q <= 16'h0000;
      done_q <= 1'b0;
      tmo_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (cmdGo && cmdOp == OP_CAPTURE) begin
      done_q <= 1'b0;
      tmo_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (state_q == ST_CAP_WAIT && tk.tick2us && cnt_q == CAP_MAX - 16'h0001
                 && !(prevLvl_q != capPol_q && capLvl == capPol_q)) begin
      result_q <= 16'h0000;
      tmo_q <= 1'b1;
      done_q <= 1'b1;
    end else if (state_q == ST_CAP_RUN && capLvl != capPol_q) begin
      // byte destinations keep only the low eight bits, as a plain truncation
      result_q <= capByte_q ? {8'h00, cnt_q[7:0]} : cnt_q;
      done_q <= 1'b1;
    end else if (state_q == ST_CAP_RUN && tk.tick2us && cnt_q == CAP_MAX) begin
      result_q <= 16'h0000;
      ovf_q <= 1'b1;
      done_q <= 1'b1;
    end
  end

  // register reads take one wait cycle so read data always comes from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      rdValid_q <= 1'b0;
      readdata_q <= 32'h0000_0000;
    end else begin
      rdValid_q <= read && !rdValid_q;
      if (read && !rdValid_q) begin
        case (address)
          REG_DIR: readdata_q <= {16'h0000, dirQ_q};
          REG_OUT: readdata_q <= {16'h0000, outQ_q};
          REG_IN: readdata_q <= {16'h0000, inLevel};
          REG_ARG: readdata_q <= {16'h0000, arg_q};
          REG_STAT: readdata_q <= {26'h0, state_q == ST_WAKE, state_q == ST_NAP, ovf_q, tmo_q,
                                   done_q, busy};
          REG_RES: readdata_q <= {16'h0000, result_q};
          default: readdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_low;
    cmdGo && cmdOp == OP_LOW |=> dirQ_q[$past(cmdPin)] && !outQ_q[$past(cmdPin)];
  endproperty
  a_low: assert property (p_low) else $error("drive-low did not set dir 1 latch 0");

  property p_output;
    cmdGo && cmdOp == OP_OUTPUT |=> dirQ_q[$past(cmdPin)]
      && outQ_q[$past(cmdPin)] == $past(outQ_q[cmdPin]);
  endproperty
  a_output: assert property (p_output) else $error("make-output changed latch");

  property p_reset;
    @(posedge clk) disable iff (1'b0) rst |=> dirQ_q == 16'h0000 && pinOe_n == 16'hffff;
  endproperty
  a_reset: assert property (p_reset) else $error("pins not inputs after reset");

  property p_wake;
    state_q == ST_WAKE |-> pinOe_n == 16'hffff && dirQ_q == $past(dirQ_q);
  endproperty
  a_wake: assert property (p_wake) else $error("pins driven during wake");

  property p_nap;
    state_q == ST_NAP |-> cnt_q < napMs && lowPower;
  endproperty
  a_nap: assert property (p_nap) else $error("nap count past its period");

  property p_pause;
    state_q == ST_PAUSE |-> cnt_q < arg_q;
  endproperty
  a_pause: assert property (p_pause) else $error("pause counted past its request");

  property p_cap_dir;
    cmdGo && cmdOp == OP_CAPTURE |=> !dirQ_q[$past(cmdPin)] && !pinOe_n[$past(cmdPin)] == 1'b0;
  endproperty
  a_cap_dir: assert property (p_cap_dir) else $error("capture pin not input");

  property p_start;
    state_q == ST_CAP_WAIT ##1 state_q == ST_CAP_RUN |-> $past(capLvl) == capPol_q
      && $past(prevLvl_q) != capPol_q && cnt_q == 16'h0000;
  endproperty
  a_start: assert property (p_start) else $error("capture started without edge");

  property p_overflow;
    ovf_q || tmo_q |-> result_q == 16'h0000;
  endproperty
  a_overflow: assert property (p_overflow) else $error("timeout gave nonzero width");

  property p_level;
    1'b1 |-> ((~pinOe_n & (inLevel ^ pinOut)) | (pinOe_n & (inLevel ^ pinIn))) == 16'h0000;
  endproperty
  a_level: assert property (p_level) else $error("input level mismatch");
endmodule
